/* File: core/sasc_exec.v */
// Execution control for the atomic swap and supervisor call instructions.
// Assumes a single-cycle memory port and an issue stage that holds the
// instruction until done is high; condition codes arrive as cond_pass.
`timescale 1ns/1ns
`include "sasc_map.vh"

module sasc_exec #(
	parameter DW = 32
) (
	input wire clock,
	input wire rst,
	input wire instr_valid,
	input wire [31:0] instr,
	input wire [DW-1:0] instr_addr,
	input wire cond_pass,
	input wire [DW-1:0] base_value,
	input wire [DW-1:0] src_value,
	input wire [DW-1:0] status_in,
	input wire big_endian,
	input wire irq_request,
	input wire [DW-1:0] mem_rdata,
	input wire mem_abort,
	output reg busy,
	output reg done,
	output reg [DW-1:0] mem_addr,
	output reg [DW-1:0] mem_wdata,
	output reg mem_req,
	output reg mem_write,
	output reg mem_byte,
	output reg [2:0] access_result_code,
	output reg irq_hold,
	output reg rf_we,
	output reg [3:0] rf_waddr,
	output reg [DW-1:0] rf_wdata,
	output reg pc_load,
	output reg [DW-1:0] pc_value,
	output reg status_we,
	output reg [DW-1:0] status_out,
	output reg [DW-1:0] supervisor_link_register,
	output reg [DW-1:0] saved_status_supervisor,
	output reg irq_taken
);

	localparam S_IDLE = 3'h0;
	localparam S_SWRD = 3'h1;
	localparam S_SWWR = 3'h2;
	localparam S_SVC2 = 3'h3;
	localparam S_SVC3 = 3'h4;
	localparam S_SVC4 = 3'h5;

	function [DW-1:0] sasc_lane;
		input [DW-1:0] word;
		input [1:0] off;
		input be;
		reg [1:0] sel;
		begin
			sel = be ? ~off : off;
			sasc_lane = {{(DW-8){1'b0}}, word[sel*8 +: 8]};
		end
	endfunction

	function [DW-1:0] sasc_mode;
		input [DW-1:0] st;
		input [4:0] m;
		begin
			sasc_mode = {st[DW-1:8], 1'b1, st[6:5], m};
		end
	endfunction

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [3:0] dest_reg;
	reg byte_reg;
	reg [DW-1:0] addr_reg;
	reg [DW-1:0] src_reg;
	reg [DW-1:0] ret_reg;
	reg [DW-1:0] stat_reg;

	wire is_swap = (instr & `SASC_SWAP_MASK) == `SASC_SWAP_PAT;
	// only bits 27:24 decide, the condition and comment fields are not looked at
	wire is_svc = (instr & `SASC_SVC_MASK) == `SASC_SVC_PAT;
	wire is_ret = (instr & `SASC_RET_MASK) == `SASC_RET_PAT;
	wire go = instr_valid && cond_pass && state_reg == S_IDLE;
	wire [1:0] lane = addr_reg[1:0];

	// Sequencing only; what each state drives is in the blocks below
	always @* begin
		state_next = state_reg;
		case (state_reg)
		S_IDLE: begin
			if (go && is_swap) begin
				state_next = S_SWRD;
			end else if (go && is_svc) begin
				state_next = S_SVC2;
			end
		end
		S_SWRD: begin
			// An aborted read goes straight back, no write follows
			if (mem_abort) begin
				state_next = S_IDLE;
			end else begin
				state_next = S_SWWR;
			end
		end
		S_SWWR: begin
			state_next = S_IDLE;
		end
		S_SVC2: begin
			state_next = S_SVC3;
		end
		S_SVC3: begin
			state_next = S_SVC4;
		end
		S_SVC4: begin
			state_next = S_IDLE;
		end
		default: begin
			state_next = S_IDLE;
		end
		endcase
	end

	// Interrupts are held off from take to completion, so a swap
	// can never be split between its read and its write
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_hold <= 1'b0;
			irq_taken <= 1'b0;
		end else begin
			irq_hold <= state_next != S_IDLE;
			irq_taken <= state_reg == S_IDLE && !instr_valid &&
				irq_request;
		end
	end

	// Operands are latched at the take edge, so equal source and
	// destination still writes the old register value to memory
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			dest_reg <= 4'h0;
			byte_reg <= 1'b0;
			addr_reg <= {DW{1'b0}};
			src_reg <= {DW{1'b0}};
			ret_reg <= {DW{1'b0}};
			stat_reg <= {DW{1'b0}};
		end else if (go) begin
			src_reg <= src_value;
			addr_reg <= base_value;
			dest_reg <= instr[`SASC_DEST_LO +: 4];
			byte_reg <= instr[`SASC_BYTE_BIT];
			ret_reg <= instr_addr + {{(DW-3){1'b0}}, 3'h4};
			stat_reg <= status_in;
		end
	end

	// Destination writeback: the loaded value waits in rf_wdata and is
	// committed only once the write half has survived
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rf_we <= 1'b0;
			rf_waddr <= 4'h0;
			rf_wdata <= {DW{1'b0}};
		end else begin
			rf_we <= state_reg == S_SWWR && !mem_abort;
			if (state_reg == S_SWRD && !mem_abort) begin
				rf_wdata <= byte_reg ? sasc_lane(mem_rdata, lane,
					big_endian) : mem_rdata;
			end
			if (state_reg == S_SWWR && !mem_abort) begin
				rf_waddr <= dest_reg;
			end
		end
	end

	// Link and saved status are simply overwritten; nested calls lose
	// the older copies unless supervisor code saved them first
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			supervisor_link_register <= {DW{1'b0}};
			saved_status_supervisor <= {DW{1'b0}};
		end else if (state_reg == S_SVC2) begin
			supervisor_link_register <= ret_reg;
			saved_status_supervisor <= stat_reg;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			busy <= 1'b0;
			done <= 1'b0;
			mem_addr <= {DW{1'b0}};
			mem_wdata <= {DW{1'b0}};
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_byte <= 1'b0;
			access_result_code <= `SASC_AR_IDLE;
			pc_load <= 1'b0;
			pc_value <= {DW{1'b0}};
			status_we <= 1'b0;
			status_out <= {DW{1'b0}};
		end else begin
			state_reg <= state_next;
			done <= 1'b0;
			pc_load <= 1'b0;
			status_we <= 1'b0;
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			access_result_code <= `SASC_AR_IDLE;
			case (state_reg)
			S_IDLE: begin
				busy <= 1'b0;
				if (go && is_swap) begin
					mem_addr <= base_value;
					mem_byte <= instr[`SASC_BYTE_BIT];
					mem_req <= 1'b1;
					access_result_code <= `SASC_AR_LOCK_READ;
					busy <= 1'b1;
				end else if (go && is_svc) begin
					busy <= 1'b1;
				end else if (go && is_ret) begin
					pc_load <= 1'b1;
					pc_value <= supervisor_link_register;
					status_we <= 1'b1;
					status_out <= saved_status_supervisor;
					done <= 1'b1;
				end else if (instr_valid) begin
					// Failed condition or other class: retire untouched
					done <= 1'b1;
				end
			end
			S_SWRD: begin
				if (mem_abort) begin
					// Write never issued, dest left alone
					pc_load <= 1'b1;
					pc_value <= `SASC_VEC_DABT;
					status_we <= 1'b1;
					status_out <= sasc_mode(status_in, `SASC_MODE_ABT);
					done <= 1'b1;
				end else begin
					mem_req <= 1'b1;
					mem_write <= 1'b1;
					mem_wdata <= byte_reg ? {4{src_reg[7:0]}} :
						src_reg;
					access_result_code <= `SASC_AR_LOCK_WRITE;
				end
			end
			S_SWWR: begin
				if (mem_abort) begin
					pc_load <= 1'b1;
					pc_value <= `SASC_VEC_DABT;
					status_we <= 1'b1;
					status_out <= sasc_mode(status_in, `SASC_MODE_ABT);
				end
				done <= 1'b1;
			end
			S_SVC2: begin
				busy <= 1'b1;
			end
			S_SVC3: begin
				status_we <= 1'b1;
				status_out <= sasc_mode(stat_reg, `SASC_MODE_SVC);
			end
			S_SVC4: begin
				// Vector load last, so the call spans its four cycles
				pc_load <= 1'b1;
				pc_value <= `SASC_VEC_SVC;
				done <= 1'b1;
			end
			default: begin
				busy <= 1'b0;
			end
			endcase
		end
	end

endmodule

/* File: core/sasc_map.vh */
// Constants for the swap and supervisor call execution block.
// Assumes a 32-bit instruction word in the usual condition/opcode layout.
`ifndef SASC_MAP_VH
`define SASC_MAP_VH
`define SASC_COND_HI 31
`define SASC_COND_LO 28
`define SASC_SWAP_MASK 32'h0FB00FF0
`define SASC_SWAP_PAT 32'h01000090
`define SASC_SVC_MASK 32'h0F000000
`define SASC_SVC_PAT 32'h0F000000
`define SASC_RET_MASK 32'h0FFFFFFF
`define SASC_RET_PAT 32'h01B0F00E
`define SASC_BYTE_BIT 22
`define SASC_BASE_LO 16
`define SASC_DEST_LO 12
`define SASC_SRC_LO 0
`define SASC_PC_REG 4'hF
`define SASC_MODE_SVC 5'h13
`define SASC_STAT_IRQ_BIT 7
`define SASC_VEC_SVC 32'h00000008
`define SASC_VEC_DABT 32'h00000010
`define SASC_MODE_ABT 5'h17
`define SASC_AR_IDLE 3'h0
`define SASC_AR_READ 3'h1
`define SASC_AR_WRITE 3'h2
`define SASC_AR_LOCK_READ 3'h5
`define SASC_AR_LOCK_WRITE 3'h6
`define SASC_SWAP_CYCLES 2
`define SASC_SVC_CYCLES 4
`endif

/* File: testbench/sasc_exec_asserts.sv */
// Port-level checks for the swap and supervisor call block.
// Bound onto every sasc_exec instance; sees only its ports.
`timescale 1ns/1ns
module sasc_exec_asserts(input wire clock, rst, mem_req, mem_write,
	mem_byte, mem_abort, irq_hold, irq_taken, done, rf_we, pc_load,
	status_we, input wire [2:0] access_result_code,
	input wire [31:0] mem_addr, mem_wdata, pc_value, status_out);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_LOCK_RD: assert property (mem_req && !mem_write |->
		access_result_code == 3'h5) else $error("read not locked");
	AST_LOCK_WR: assert property (mem_req && mem_write |->
		access_result_code == 3'h6) else $error("write not locked");
	AST_RD_WR: assert property (mem_req && !mem_write && !mem_abort |=>
		mem_req && mem_write) else $error("no write after read");
	AST_RD_ABT: assert property (mem_req && !mem_write && mem_abort |=>
		!mem_req && pc_load && pc_value == 32'h10)
		else $error("write after aborted read");
	AST_WR_ABT: assert property (mem_req && mem_write && mem_abort |=>
		pc_load && !rf_we) else $error("aborted write committed");
	AST_NO_IRQ: assert property (mem_req |-> irq_hold && !irq_taken)
		else $error("interrupt inside swap");
	AST_SAME_ADDR: assert property (mem_req && mem_write |->
		mem_addr == $past(mem_addr)) else $error("write address moved");
	AST_SWAP_END: assert property (mem_req && mem_write && !mem_abort |=>
		done && rf_we) else $error("swap not two accesses");
	AST_BYTE: assert property (mem_req && mem_write && mem_byte |->
		mem_wdata[31:8] == {3{mem_wdata[7:0]}}) else $error("byte lanes");
	AST_SVC: assert property (status_we && !pc_load &&
		status_out[4:0] == 5'h13 |-> status_out[7] ##1 pc_load &&
		pc_value == 32'h8 && done) else $error("trap entry wrong");
	AST_IRQ_IDLE: assert property (irq_taken |-> !irq_hold)
		else $error("interrupt taken while held");
	AST_REQ_HOLD: assert property (mem_req |=>
		irq_hold || done) else $error("hold dropped mid swap");
endmodule
bind sasc_exec sasc_exec_asserts sasc_exec_asserts_i (.*);

/* File: testbench/sasc_exec_tb.sv */
// Random self-checking bench for sasc_exec with a memory model.
// Expectations come from a one-word memory image taken before each op.
`timescale 1ns/1ns
module sasc_exec_tb;
	reg clock = 0, rst = 1, instr_valid = 0, cond_pass = 1, ab_r = 0;
	reg ab_w = 0, big_endian = 0, irq_request = 0;
	reg [31:0] instr = 0, instr_addr = 0, base_value = 0, src_value = 0;
	reg [31:0] status_in = 0, lf = 32'hAF1359D8;
	reg [31:0] exp_link = 0, exp_stat = 0, last_addr = 0;
	wire [31:0] mem_rdata, mem_addr, mem_wdata, rf_wdata, pc_value;
	wire [31:0] status_out, supervisor_link_register, mem_word;
	wire [31:0] saved_status_supervisor;
	wire mem_abort, busy, done, mem_req, mem_write, mem_byte, irq_hold;
	wire rf_we, pc_load, status_we, irq_taken;
	wire [2:0] access_result_code;
	wire [3:0] rf_waddr;
	integer error_cnt = 0, cmp_count = 0, n, k, reqs, wes;
	sasc_exec sasc_exec_i (.*);
	sasc_mem_model sasc_mem_model_i (.*);
	initial forever #25 clock = ~clock;
	always @(posedge clock) begin
		reqs = reqs + mem_req;
		wes = wes + rf_we;
		if (mem_req)
			last_addr = mem_addr;
	end
	function [31:0] nxt(input [31:0] x);
		nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task chk(input [31:0] a, e);
		begin
			cmp_count = cmp_count + 1;
			if (a !== e) begin
				error_cnt = error_cnt + 1;
				$display("Error %0t got %h exp %h", $time, a, e);
			end
		end
	endtask
	task end_of_test;
		begin
			if (error_cnt == 0 && cmp_count > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// Ops: 0 word, 1 byte, 2 read abort, 3 write abort, 4 call, 5 return
	task op(input [2:0] t);
		reg [31:0] x, o, nw;
		reg [4:0] sh;
		begin
			lf = nxt(lf);
			x = lf;
			o = mem_word;
			base_value = x;
			src_value = nxt(x);
			big_endian = x[9];
			irq_request = x[11];
			instr_addr = {x[31:2], 2'h0};
			status_in = x ^ 32'h5A5A0000;
			ab_r = (t == 2);
			ab_w = (t == 3);
			// Comment field kept below the reserved range; no operand is 15
			instr = t == 5 ? 32'hE1B0F00E : t == 4 ? {8'hEF, 1'b0, x[22:0]} :
				{8'hE1, 1'b0, t[0], 2'h0, 1'b0, x[2:0], 1'b0, x[6:4],
				8'h09, 1'b0, x[10:8]};
			sh = {base_value[1:0] ^ {2{big_endian}}, 3'h0};
			nw = t[0] ? (o & ~(32'hFF << sh)) | (src_value[7:0] << sh)
				: src_value;
			reqs = 0;
			wes = 0;
			n = 0;
			instr_valid = 1;
			do begin
				@(negedge clock);
				n = n + 1;
			end while (done !== 1'b1 && n < 9);
			instr_valid = 0;
			@(negedge clock);
			if (!cond_pass) begin
				chk(reqs + wes, 0);
				chk(n, 1);
			end else if (t < 4) begin
				chk(reqs, t == 2 ? 1 : 2);
				chk(last_addr, base_value);
				chk(wes, t < 2);
				chk(mem_word, t > 1 ? o : nw);
				if (t < 2) chk(rf_wdata, t[0] ? o >> sh & 32'hFF : o);
				if (t < 2) chk(rf_waddr, x[6:4]);
				if (t > 1) chk(pc_value, 32'h10);
			end else if (t == 4) begin
				chk(n, 4);
				chk(supervisor_link_register, instr_addr + 4);
				chk(saved_status_supervisor, status_in);
				exp_link = instr_addr + 4;
				exp_stat = status_in;
			end else begin
				chk(pc_value, exp_link);
				chk(status_out, exp_stat);
			end
			chk(irq_taken, x[11]);
		end
	endtask
	initial begin
		#(50 * 3000);
		error_cnt = error_cnt + 1;
		end_of_test;
	end
	initial begin
		repeat (4) @(negedge clock);
		rst = 0;
		for (k = 0; k < 84; k = k + 1) begin
			cond_pass = (k % 7 != 6);
			op(k % 6);
		end
		end_of_test;
	end
endmodule

/* File: testbench/sasc_mem_model.sv */
// One-word memory manager standing on the far side of the core.
// Aborts are commanded by the bench through ab_r and ab_w.
`timescale 1ns/1ns
module sasc_mem_model(input wire clock, big_endian, mem_req, mem_write,
	mem_byte, ab_r, ab_w, input wire [31:0] mem_addr, mem_wdata,
	output wire [31:0] mem_rdata, output wire mem_abort,
	output reg [31:0] mem_word = 32'h1234ABCD);
	wire [4:0] sh = {mem_addr[1:0] ^ {2{big_endian}}, 3'h0};
	// Never withdraws the bus; idle data is inverted, not left stale
	assign mem_rdata = mem_req ? mem_word : ~mem_word;
	assign mem_abort = mem_req & (mem_write ? ab_w : ab_r);
	always @(posedge clock) begin
		if (mem_req & mem_write & ~mem_abort)
			mem_word <= mem_byte ? (mem_word & ~(32'hFF << sh)) |
				(mem_wdata & (32'hFF << sh)) : mem_wdata;
	end
endmodule
